// *** rtl/sensor_hub_regs.svh ***
/*
  Constants of the sensor hub: clock periods, link rate, data-ready pulse rate,
  measurement offset step, sample period and burst length encodings.
  Assumes it is included by bare name from the hub's design file.
*/
`ifndef SENSOR_HUB_REGS_SVH
`define SENSOR_HUB_REGS_SVH

`define HUB_CLK_PERIOD_NS 50
`define HUB_LINK_PERIOD_NS 64
`define HUB_I2C_RATE_HZ 400000
`define HUB_DRDY_RATE_HZ 6400
`define HUB_OFFSET_STEP_US 2500
`define HUB_ODR_PERIOD_US 40000
`define HUB_BURST_SEL0_LEN 4'h1
`define HUB_BURST_SEL1_LEN 4'h2
`define HUB_BURST_SEL2_LEN 4'h6
`define HUB_BURST_SEL3_LEN 4'h8
`define HUB_DATA_BYTES 8
`define HUB_DRDY_BYTE 6
`define HUB_DRDY_BIT 0

`endif

// *** rtl/sensor_hub_pkg.sv ***
/*
  Types shared by the sensor hub: the transfer request carried across the
  clock crossing and the state enumeration of the link domain.
  Assumes the constants header is available for inclusion.
*/
`default_nettype none
package sensor_hub_pkg;
  typedef struct packed {
    logic is_read;
    logic [6:0] dev_addr;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
    logic [3:0] len;
  } link_req_t;

  typedef enum logic [2:0] {L_IDLE, L_START, L_TX, L_RX, L_STOP} link_state_t;
endpackage
`default_nettype wire

// *** rtl/sensor_i2c_hub.sv ***
/*
  Auxiliary sensor hub: the I2C master toward one external sensor, the setup
  mode for indirect access and the data-mode readout loop with data-ready.
  Assumes host controls arrive on i_clock, the link logic runs on i_link_clock
  and the open-drain pins are resolved outside with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Configured hub fetches sensor samples alone into data bytes and the FIFO.
// - Data-mode loop runs only while enable is one; enable resets to zero.
// - Clearing enable just stops the loop; no power-mode transfer is issued.
// - Manual, power save and enable select off, setup or data mode.
// - SCL runs at most 400 kHz (about 390 kHz), about 230 us for ten bytes.
// - Setup-mode read-address write starts a burst read of 1, 2, 6 or 8 bytes into bytes from zero.
// - Setup-mode write-address write sends exactly one data byte.
// - Busy sets on a trigger and clears on completion.
// - Data mode reads the burst; ready comes from byte six bit zero.
// - Data-ready event fires on each complete new sample set.
// - Non-latched pin drops one 6400 Hz period after rising.
// - Status read clears interrupt flag; data read clears ready flag.
// - Data-ready reaches a pin only when its map bit is set.
// - Data mode writes the forced-mode trigger before every readout.
// - After the trigger, wait the offset, then burst-read the sample.
// - Bytes beyond a short burst stay undefined; they are left untouched.
// - Trigger leads the update by 2.5 to 37.5 ms.
// - Offset zero triggers right after the update, seen next update.
// - Latched status and pin clear on read; a same-cycle event keeps them set.
`include "sensor_hub_regs.svh"
module sensor_i2c_hub #(
  parameter int OFFSET_STEP_CYC = `HUB_OFFSET_STEP_US * 1000 / `HUB_CLK_PERIOD_NS,
  parameter int ODR_PERIOD_CYC = `HUB_ODR_PERIOD_US * 1000 / `HUB_CLK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clock,
  input wire logic i_iface_enable,
  input wire logic i_manual_en,
  input wire logic i_adv_power_save,
  input wire logic i_latched_int,
  input wire logic [1:0] i_burst_sel,
  input wire logic [3:0] i_offset_sel,
  input wire logic [6:0] i_dev_addr,
  input wire logic i_rd_addr_write,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_wr_addr_write,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_int_status_read,
  input wire logic i_data_read,
  input wire logic i_map_int1,
  input wire logic i_map_int2,
  input wire logic i_sda_in,
  output logic o_busy,
  output logic [63:0] o_data,
  output logic o_fifo_push,
  output logic o_drdy_status,
  output logic o_int_status,
  output logic o_int1,
  output logic o_int2,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  output logic o_sda_out,
  output logic o_sda_oe_n
);
  localparam int QUARTER_NS = 1000000000 / (`HUB_I2C_RATE_HZ * 4);
  localparam int QUARTER_CYC = (QUARTER_NS + `HUB_LINK_PERIOD_NS - 1) / `HUB_LINK_PERIOD_NS;
  localparam int DRDY_CYC = (1000000000 / `HUB_DRDY_RATE_HZ) / `HUB_CLK_PERIOD_NS;

  function automatic logic [3:0] burst_len(input logic [1:0] sel);
    case (sel)
      2'h0: burst_len = `HUB_BURST_SEL0_LEN;
      2'h1: burst_len = `HUB_BURST_SEL1_LEN;
      2'h2: burst_len = `HUB_BURST_SEL2_LEN;
      default: burst_len = `HUB_BURST_SEL3_LEN;
    endcase
  endfunction

  // Host-side domain.
  logic [7:0] rd_addr_reg, wr_addr_reg, wr_data_reg;
  sensor_hub_pkg::link_req_t req_reg, req_next;
  logic req_tgl_reg, busy_reg, cur_data_reg, meas_pend_reg;
  logic done_s1_reg, done_s2_reg, done_s3_reg;
  logic [31:0] pc_reg;
  logic [63:0] data_reg;
  logic fifo_push_reg, int_status_reg, drdy_status_reg;
  logic [31:0] pulse_cnt_reg;
  logic [7:0] link_rdata [`HUB_DATA_BYTES];
  logic link_done_tgl_reg;

  wire data_mode = ~i_manual_en & i_iface_enable;
  wire setup_mode = i_manual_en & ~i_adv_power_save & ~i_iface_enable;
  wire done_edge = done_s2_reg ^ done_s3_reg;
  wire [31:0] offset_cyc = 32'(i_offset_sel) * 32'(OFFSET_STEP_CYC);
  wire [31:0] trig_at = 32'(ODR_PERIOD_CYC) - offset_cyc;
  wire setup_rd = setup_mode & i_rd_addr_write & ~busy_reg;
  wire setup_wr = setup_mode & i_wr_addr_write & ~busy_reg;
  wire read_go = data_mode & ~busy_reg & (pc_reg == 32'(ODR_PERIOD_CYC - 1));
  wire meas_go = data_mode & ~busy_reg & meas_pend_reg & ~read_go;
  wire launch = setup_rd | setup_wr | read_go | meas_go;
  wire launch_read = setup_rd | read_go;
  wire drdy_event = done_edge & req_reg.is_read & cur_data_reg
                    & link_rdata[`HUB_DRDY_BYTE][`HUB_DRDY_BIT];
  wire pin_level = i_latched_int ? int_status_reg : (pulse_cnt_reg != 32'h0);

  // A setup read uses the address just written; data mode uses the stored one.
  assign req_next.is_read = launch_read;
  assign req_next.dev_addr = i_dev_addr;
  assign req_next.reg_addr = setup_rd ? i_rd_addr : (setup_wr ? i_wr_addr
                             : (read_go ? rd_addr_reg : wr_addr_reg));
  assign req_next.wdata = wr_data_reg;
  assign req_next.len = launch_read ? burst_len(i_burst_sel) : 4'h1;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      rd_addr_reg <= 8'h00;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      if (i_rd_addr_write)
        rd_addr_reg <= i_rd_addr;
      if (i_wr_addr_write)
        wr_addr_reg <= i_wr_addr;
      // Data byte is frozen while busy, so a late rewrite cannot tear a transfer.
      if (!busy_reg)
        wr_data_reg <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      req_reg <= '0;
      req_tgl_reg <= 1'b0;
      busy_reg <= 1'b0;
      cur_data_reg <= 1'b0;
    end
    else if (launch)
    begin
      req_reg <= req_next;
      req_tgl_reg <= ~req_tgl_reg;
      busy_reg <= 1'b1;
      cur_data_reg <= data_mode;
    end
    else if (done_edge)
      busy_reg <= 1'b0;
  end

  // Leaving data mode only stops scheduling; a transfer in flight completes.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || !data_mode)
    begin
      pc_reg <= 32'h0;
      meas_pend_reg <= 1'b0;
    end
    else
    begin
      pc_reg <= (pc_reg == 32'(ODR_PERIOD_CYC - 1)) ? 32'h0 : pc_reg + 32'h1;
      if (meas_go)
        meas_pend_reg <= 1'b0;
      else if ((i_offset_sel != 4'h0 && pc_reg == trig_at)
               || (i_offset_sel == 4'h0 && done_edge && req_reg.is_read))
        meas_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end
    else
    begin
      done_s1_reg <= link_done_tgl_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `HUB_DATA_BYTES; g++)
    begin : g_data
      // Bytes past a short burst keep old content.
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
          data_reg[g*8 +: 8] <= 8'h00;
        else if (done_edge && req_reg.is_read && 4'(g) < req_reg.len)
          data_reg[g*8 +: 8] <= link_rdata[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      fifo_push_reg <= 1'b0;
      int_status_reg <= 1'b0;
      drdy_status_reg <= 1'b0;
      pulse_cnt_reg <= 32'h0;
    end
    else
    begin
      fifo_push_reg <= drdy_event;
      int_status_reg <= drdy_event | (int_status_reg & ~i_int_status_read);
      drdy_status_reg <= drdy_event | (drdy_status_reg & ~i_data_read);
      if (drdy_event)
        pulse_cnt_reg <= 32'(DRDY_CYC);
      else if (pulse_cnt_reg != 32'h0)
        pulse_cnt_reg <= pulse_cnt_reg - 32'h1;
    end
  end

  assign o_busy = busy_reg;
  assign o_data = data_reg;
  assign o_fifo_push = fifo_push_reg;
  assign o_drdy_status = drdy_status_reg;
  assign o_int_status = int_status_reg;
  assign o_int1 = pin_level & i_map_int1;
  assign o_int2 = pin_level & i_map_int2;

  // Link domain. Request fields are stable while busy, so they cross by toggle.
  logic l_rst_s1, l_rst_n;
  logic l_req_s1_reg, l_req_s2_reg, l_req_s3_reg, l_sda_s1_reg, l_sda_s2_reg;
  sensor_hub_pkg::link_state_t l_state_reg;
  sensor_hub_pkg::link_req_t l_req_reg;
  logic [7:0] l_q_reg, l_sh_reg;
  logic [1:0] l_ph_reg;
  logic [3:0] l_bit_reg, l_rcnt_reg;
  logic [2:0] l_step_reg;
  logic l_scl_low_reg, l_sda_low_reg;

  wire l_req_edge = l_req_s2_reg ^ l_req_s3_reg;
  wire l_tick = (l_q_reg == 8'(QUARTER_CYC - 1));
  wire l_end = l_tick & (l_ph_reg == 2'h3);
  wire l_last = (l_rcnt_reg == l_req_reg.len - 4'h1);

  always_ff @(posedge i_link_clock)
  begin
    l_rst_s1 <= i_rst_n;
    l_rst_n <= l_rst_s1;
  end

  always_ff @(posedge i_link_clock)
  begin
    if (!l_rst_n)
    begin
      l_req_s1_reg <= 1'b0;
      l_req_s2_reg <= 1'b0;
      l_req_s3_reg <= 1'b0;
      l_sda_s1_reg <= 1'b1;
      l_sda_s2_reg <= 1'b1;
    end
    else
    begin
      l_req_s1_reg <= req_tgl_reg;
      l_req_s2_reg <= l_req_s1_reg;
      l_req_s3_reg <= l_req_s2_reg;
      l_sda_s1_reg <= i_sda_in;
      l_sda_s2_reg <= l_sda_s1_reg;
    end
  end

  always_ff @(posedge i_link_clock)
  begin
    if (!l_rst_n || l_state_reg == sensor_hub_pkg::L_IDLE)
    begin
      l_q_reg <= 8'h00;
      l_ph_reg <= 2'h0;
    end
    else
    begin
      l_q_reg <= l_tick ? 8'h00 : l_q_reg + 8'h01;
      if (l_tick)
        l_ph_reg <= l_ph_reg + 2'h1;
    end
  end

  // Phase 0 sets data with SCL low, 1 raises SCL, 2 samples, 3 lowers SCL.
  always_ff @(posedge i_link_clock)
  begin
    if (!l_rst_n)
    begin
      l_state_reg <= sensor_hub_pkg::L_IDLE;
      l_req_reg <= '0;
      l_sh_reg <= 8'h00;
      l_bit_reg <= 4'h0;
      l_rcnt_reg <= 4'h0;
      l_step_reg <= 3'h0;
      l_scl_low_reg <= 1'b0;
      l_sda_low_reg <= 1'b0;
      link_done_tgl_reg <= 1'b0;
      for (int i = 0; i < `HUB_DATA_BYTES; i++)
        link_rdata[i] <= 8'h00;
    end
    else
    begin
      case (l_state_reg)
        sensor_hub_pkg::L_IDLE:
          if (l_req_edge)
          begin
            l_req_reg <= req_reg;
            l_state_reg <= sensor_hub_pkg::L_START;
            l_step_reg <= 3'h0;
            l_rcnt_reg <= 4'h0;
          end
        sensor_hub_pkg::L_START:
          if (l_tick)
          begin
            case (l_ph_reg)
              2'h0: l_sda_low_reg <= 1'b0;
              2'h1: l_scl_low_reg <= 1'b0;
              2'h2: l_sda_low_reg <= 1'b1;
              default:
              begin
                l_scl_low_reg <= 1'b1;
                l_state_reg <= sensor_hub_pkg::L_TX;
                l_bit_reg <= 4'h0;
                l_sh_reg <= {l_req_reg.dev_addr, l_step_reg != 3'h0};
                l_step_reg <= (l_step_reg == 3'h0) ? 3'h1 : 3'h4;
              end
            endcase
          end
        sensor_hub_pkg::L_TX:
          if (l_tick)
          begin
            case (l_ph_reg)
              2'h0: l_sda_low_reg <= (l_bit_reg != 4'h8) & ~l_sh_reg[7];
              2'h1: l_scl_low_reg <= 1'b0;
              2'h2: l_scl_low_reg <= 1'b0;
              default:
              begin
                l_scl_low_reg <= 1'b1;
                l_sh_reg <= {l_sh_reg[6:0], 1'b0};
                l_bit_reg <= l_bit_reg + 4'h1;
                if (l_bit_reg == 4'h8)
                begin
                  l_bit_reg <= 4'h0;
                  l_step_reg <= l_step_reg + 3'h1;
                  case (l_step_reg)
                    3'h1: l_sh_reg <= l_req_reg.reg_addr;
                    3'h2:
                      if (l_req_reg.is_read)
                        l_state_reg <= sensor_hub_pkg::L_START;
                      else
                        l_sh_reg <= l_req_reg.wdata;
                    3'h4: l_state_reg <= sensor_hub_pkg::L_RX;
                    default: l_state_reg <= sensor_hub_pkg::L_STOP;
                  endcase
                end
              end
            endcase
          end
        sensor_hub_pkg::L_RX:
          if (l_tick)
          begin
            case (l_ph_reg)
              2'h0: l_sda_low_reg <= (l_bit_reg == 4'h8) & ~l_last;
              2'h1: l_scl_low_reg <= 1'b0;
              2'h2:
                if (l_bit_reg != 4'h8)
                  l_sh_reg <= {l_sh_reg[6:0], l_sda_s2_reg};
              default:
              begin
                l_scl_low_reg <= 1'b1;
                l_bit_reg <= l_bit_reg + 4'h1;
                if (l_bit_reg == 4'h7)
                  link_rdata[l_rcnt_reg[2:0]] <= l_sh_reg;
                if (l_bit_reg == 4'h8)
                begin
                  l_bit_reg <= 4'h0;
                  l_rcnt_reg <= l_rcnt_reg + 4'h1;
                  if (l_last)
                    l_state_reg <= sensor_hub_pkg::L_STOP;
                end
              end
            endcase
          end
        sensor_hub_pkg::L_STOP:
          if (l_tick)
          begin
            case (l_ph_reg)
              2'h0: l_sda_low_reg <= 1'b1;
              2'h1: l_scl_low_reg <= 1'b0;
              2'h2: l_sda_low_reg <= 1'b0;
              default:
              begin
                l_state_reg <= sensor_hub_pkg::L_IDLE;
                link_done_tgl_reg <= ~link_done_tgl_reg;
              end
            endcase
          end
        default: l_state_reg <= sensor_hub_pkg::L_IDLE;
      endcase
    end
  end

  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe_n = ~l_scl_low_reg;
  assign o_sda_oe_n = ~l_sda_low_reg;

  // Helper for the pulse-width check: cycles the non-latched level has stood.
  logic [31:0] hi_cnt_reg;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || drdy_event || !pin_level)
      hi_cnt_reg <= 32'h0;
    else
      hi_cnt_reg <= hi_cnt_reg + 32'h1;
  end

  sequence s_start_hold;
    (l_state_reg == sensor_hub_pkg::L_START) [*2];
  endsequence

  a_busy_on_trigger: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (setup_rd || setup_wr) |=> busy_reg && req_reg.is_read == $past(setup_rd))
    else $error("busy or request kind wrong after trigger");
  a_busy_clears_done: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(busy_reg) |-> $past(done_edge))
    else $error("busy cleared without completion");
  a_pulse_width: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(pin_level) && !i_latched_int |-> hi_cnt_reg == 32'(DRDY_CYC))
    else $error("non-latched pulse width wrong");
  a_pin_mapping: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_map_int1 |-> !o_int1) and (!i_map_int2 |-> !o_int2))
    else $error("unmapped pin asserted");
  a_status_set_wins: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    drdy_event |=> o_int_status && o_drdy_status ##1 fifo_push_reg == 1'b0)
    else $error("event lost against clear");
  a_status_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_int_status_read && !drdy_event |=> !o_int_status)
    else $error("status read did not clear flag");
  a_ready_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_data_read && !drdy_event |=> !o_drdy_status)
    else $error("data read did not clear ready");
  a_no_idle_launch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !data_mode && !setup_mode && !busy_reg |=> !busy_reg)
    else $error("transfer started outside setup or data mode");
  a_drdy_source: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    drdy_event |=> o_data[`HUB_DRDY_BYTE*8 + `HUB_DRDY_BIT] && o_fifo_push)
    else $error("ready not tied to byte six bit zero");
  a_link_start: assert property (@(posedge i_link_clock) disable iff (!l_rst_n)
    l_req_edge && l_state_reg == sensor_hub_pkg::L_IDLE |=> s_start_hold)
    else $error("link did not begin with a start condition");
  a_write_single: assert property (@(posedge i_link_clock) disable iff (!l_rst_n)
    l_state_reg == sensor_hub_pkg::L_RX |-> l_req_reg.is_read)
    else $error("write transfer entered read phase");
  a_scl_quarter: assert property (@(posedge i_link_clock) disable iff (!l_rst_n)
    $rose(l_scl_low_reg) |=> !l_tick [*8])
    else $error("link quarter period too short");
endmodule
`default_nettype wire

// *** bench/aux_sensor_model.sv ***
/*
  Behavioural model of one I2C sensor on the far side of the hub.
  Assumes SCL and SDA are resolved open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module aux_sensor_model #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe_n,
  output var int o_wr_count,
  output var int o_rd_count,
  output logic [7:0] o_last_reg,
  output logic [7:0] o_last_data
);
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic active;
  logic rd_mode;
  logic nack;
  int bits;
  int nbyte;

  // Contents are a fixed function of the address, so the bench can predict every read.
  task automatic load_byte();
    tx_reg = ptr_reg ^ 8'ha5;
    ptr_reg = ptr_reg + 8'h01;
    o_sda_oe_n = tx_reg[7];
  endtask

  initial
  begin
    o_sda_oe_n = 1'b1;
    o_wr_count = 0;
    o_rd_count = 0;
    active = 1'b0;
  end

  // The model never drives SCL: the hub is the only master on the link.
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      active = 1'b1;
      bits = 0;
      nbyte = 0;
      rd_mode = 1'b0;
      o_sda_oe_n = 1'b1;
    end

  always @(posedge i_sda)
    if (i_scl === 1'b1)
    begin
      active = 1'b0;
      o_sda_oe_n = 1'b1;
    end

  always @(posedge i_scl)
    if (active)
    begin
      bits = bits + 1;
      if (rd_mode && nbyte > 0)
        nack = i_sda;
      else
        shift_reg = {shift_reg[6:0], i_sda};
    end

  always @(negedge i_scl)
    if (active && rd_mode && nbyte > 0)
    begin
      if (bits == 9)
      begin
        bits = 0;
        if (nack)
          active = 1'b0;
        if (nack)
          o_sda_oe_n = 1'b1;
        else
          load_byte();
      end
      else
        o_sda_oe_n = (bits == 8) ? 1'b1 : tx_reg[7 - bits];
    end
    else if (active && bits == 8)
    begin
      if (nbyte == 0 && shift_reg[7:1] != DEV_ADDR)
        active = 1'b0;
      else
        o_sda_oe_n = 1'b0;
      if (active && nbyte == 0)
        rd_mode = shift_reg[0];
      if (active && nbyte == 0 && shift_reg[0])
        o_rd_count = o_rd_count + 1;
      if (nbyte == 1)
        ptr_reg = shift_reg;
      if (nbyte == 2)
      begin
        o_last_reg = ptr_reg;
        o_last_data = shift_reg;
        o_wr_count = o_wr_count + 1;
      end
    end
    else if (active && bits == 9)
    begin
      bits = 0;
      nbyte = nbyte + 1;
      if (rd_mode)
        load_byte();
      else
        o_sda_oe_n = 1'b1;
    end
endmodule
`default_nettype wire

// *** bench/aux_sensor_i2c_hub_tb_top.sv ***
/*
  Bench of the sensor hub: setup reads and writes, refusals, data-mode loop,
  data-ready signalling and disable.
  Assumes the sensor model answers at address 7'h10 behind pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module aux_sensor_i2c_hub_tb_top;
  localparam int STEP = 500;
  localparam int ODR = 10000;
  logic i_clock, i_rst_n, i_link_clock, i_iface_enable, i_manual_en, i_adv_power_save;
  logic i_latched_int, i_rd_addr_write, i_wr_addr_write, i_int_status_read, i_data_read;
  logic i_map_int1, i_map_int2;
  logic [1:0] i_burst_sel;
  logic [3:0] i_offset_sel;
  logic [7:0] i_rd_addr, i_wr_addr, i_wr_data;
  wire logic o_busy, o_fifo_push, o_drdy_status, o_int_status, o_int1, o_int2;
  wire logic o_scl_oe_n, o_sda_oe_n, model_oe_n, scl_w, sda_w;
  wire logic [63:0] o_data;
  wire logic [7:0] last_reg, last_data;
  int wr_count, rd_count;
  logic [63:0] exp_data;
  int n_errors = 0;
  int n_tests = 0;

  assign scl_w = o_scl_oe_n ? 1'b1 : 1'b0;
  assign sda_w = o_sda_oe_n & model_oe_n;

  sensor_i2c_hub #(.OFFSET_STEP_CYC(STEP), .ODR_PERIOD_CYC(ODR)) dut_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clock(i_link_clock),
    .i_iface_enable(i_iface_enable), .i_manual_en(i_manual_en),
    .i_adv_power_save(i_adv_power_save), .i_latched_int(i_latched_int),
    .i_burst_sel(i_burst_sel), .i_offset_sel(i_offset_sel), .i_dev_addr(7'h10),
    .i_rd_addr_write(i_rd_addr_write), .i_rd_addr(i_rd_addr), .i_wr_addr_write(i_wr_addr_write),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_int_status_read(i_int_status_read),
    .i_data_read(i_data_read), .i_map_int1(i_map_int1), .i_map_int2(i_map_int2),
    .i_sda_in(sda_w), .o_busy(o_busy), .o_data(o_data), .o_fifo_push(o_fifo_push),
    .o_drdy_status(o_drdy_status), .o_int_status(o_int_status), .o_int1(o_int1),
    .o_int2(o_int2), .o_scl_out(), .o_scl_oe_n(o_scl_oe_n), .o_sda_out(),
    .o_sda_oe_n(o_sda_oe_n));

  aux_sensor_model #(.DEV_ADDR(7'h10)) model_u (.i_scl(scl_w), .i_sda(sda_w),
    .o_sda_oe_n(model_oe_n), .o_wr_count(wr_count), .o_rd_count(rd_count),
    .o_last_reg(last_reg), .o_last_data(last_data));

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial
  begin
    i_link_clock = 1'b0;
    #7;
    forever #32 i_link_clock = ~i_link_clock;
  end

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(string what);
    n_errors++;
    $display("[FAIL] %s expected done seen timeout", what);
    report_and_stop();
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  task automatic wait_idle(int lim);
    int n;
    for (n = 0; n < lim && o_busy !== 1'b0; n++)
      tick();
    if (n == lim)
      timeout("busy");
  endtask

  task automatic wait_push(int lim);
    int n;
    for (n = 0; n < lim && o_fifo_push !== 1'b1; n++)
      tick();
    if (n == lim)
      timeout("push");
  endtask

  task automatic set_mode(logic man, logic aps, logic en);
    i_manual_en = man;
    i_adv_power_save = aps;
    i_iface_enable = en;
    tick(2);
  endtask

  task automatic setup_write(logic [7:0] addr, logic [7:0] data);
    int wc;
    int rc;
    set_mode(1'b1, 1'b0, 1'b0);
    i_burst_sel = 2'h3;
    i_wr_data = data;
    wc = wr_count;
    rc = rd_count;
    tick();
    i_wr_addr = addr;
    i_wr_addr_write = 1'b1;
    tick();
    i_wr_addr_write = 1'b0;
    tick();
    check("busy on write", 1, o_busy);
    wait_idle(6000);
    check("write count", wc + 1, wr_count);
    check("no read on write", rc, rd_count);
    check("write reg", addr, last_reg);
    check("write data", data, last_data);
  endtask

  task automatic setup_read(logic [1:0] sel, logic [7:0] addr);
    int len;
    int rc;
    len = (sel == 0) ? 1 : (sel == 1) ? 2 : (sel == 2) ? 6 : 8;
    set_mode(1'b1, 1'b0, 1'b0);
    i_burst_sel = sel;
    rc = rd_count;
    i_rd_addr = addr;
    i_rd_addr_write = 1'b1;
    tick();
    i_rd_addr_write = 1'b0;
    tick();
    check("busy on read", 1, o_busy);
    wait_idle(7000);
    for (int i = 0; i < len; i++)
      exp_data[8*i +: 8] = (addr + 8'(i)) ^ 8'ha5;
    check("read count", rc + 1, rd_count);
    check("read data", exp_data, o_data);
  endtask

  task automatic refused();
    int rc;
    int wc;
    rc = rd_count;
    wc = wr_count;
    set_mode(1'b1, 1'b1, 1'b0);
    i_rd_addr_write = 1'b1;
    tick();
    i_rd_addr_write = 1'b0;
    tick(20);
    check("no access busy", 0, o_busy);
    set_mode(1'b1, 1'b0, 1'b0);
    i_burst_sel = 2'h0;
    i_rd_addr_write = 1'b1;
    tick();
    i_rd_addr_write = 1'b0;
    tick(3);
    i_wr_addr_write = 1'b1;
    tick();
    i_wr_addr_write = 1'b0;
    wait_idle(6000);
    exp_data[7:0] = i_rd_addr ^ 8'ha5;
    check("read while off", rc + 1, rd_count);
    check("refused read data", exp_data, o_data);
    check("write while busy", wc, wr_count);
  endtask

  task automatic data_mode();
    int n;
    int wc;
    logic seen_low;
    setup_write(8'h4b, 8'h02);
    setup_read(2'h3, 8'h42);
    i_offset_sel = 4'h4;
    i_latched_int = 1'b0;
    i_map_int1 = 1'b1;
    i_map_int2 = 1'b0;
    set_mode(1'b0, 1'b0, 1'b1);
    for (n = 0; n < ODR + 100 && o_busy !== 1'b1; n++)
      tick();
    if (n == ODR + 100)
      timeout("trigger");
    wc = wr_count;
    seen_low = 1'b0;
    for (n = 1; n < ODR; n++)
    begin
      tick();
      if (o_busy === 1'b0)
        seen_low = 1'b1;
      if (o_busy === 1'b1 && seen_low)
        break;
    end
    check("offset gap", 1, n >= 4 * STEP - 4 && n <= 4 * STEP + 2);
    check("trigger write", wc + 1, wr_count);
    check("trigger reg", 8'h4b, last_reg);
    wait_push(7000);
    check("sample", exp_data, o_data);
    check("ready flag", 1, o_drdy_status);
    check("int flag", 1, o_int_status);
    check("pins", 2'b10, {o_int1, o_int2});
    for (n = 0; n < 4000 && o_int1 === 1'b1; n++)
      tick();
    check("pulse length", 3125, n);
    i_int_status_read = 1'b1;
    tick();
    i_int_status_read = 1'b0;
    tick(2);
    check("int cleared", 2'b01, {o_int_status, o_drdy_status});
    i_data_read = 1'b1;
    tick();
    i_data_read = 1'b0;
    tick(2);
    check("ready cleared", 0, o_drdy_status);
  endtask

  task automatic latched_zero();
    int wc;
    i_latched_int = 1'b1;
    i_map_int1 = 1'b0;
    i_map_int2 = 1'b1;
    i_offset_sel = 4'h0;
    tick();
    wait_push(ODR + 7000);
    wc = wr_count;
    tick(3200);
    check("trigger after update", wc + 1, wr_count);
    check("latched pins", 2'b01, {o_int1, o_int2});
    i_int_status_read = 1'b1;
    tick();
    i_int_status_read = 1'b0;
    tick(3);
    check("latched clear", 2'b00, {o_int_status, o_int2});
  endtask

  task automatic disable_iface();
    int wc;
    int rc;
    set_mode(1'b0, 1'b0, 1'b0);
    wait_idle(7000);
    wc = wr_count;
    rc = rd_count;
    tick(ODR + 2000);
    check("no writes off", wc, wr_count);
    check("no reads off", rc, rd_count);
    check("scl released", 1, o_scl_oe_n);
  endtask

  initial
  begin
    {i_rst_n, i_iface_enable, i_adv_power_save, i_latched_int} = 4'h0;
    {i_rd_addr_write, i_wr_addr_write, i_int_status_read, i_data_read} = 4'h0;
    {i_map_int1, i_map_int2, i_manual_en} = 3'h1;
    i_burst_sel = 2'h3;
    i_offset_sel = 4'h0;
    {i_rd_addr, i_wr_addr, i_wr_data} = 24'h0;
    exp_data = 64'h0;
    tick(20);
    i_rst_n = 1'b1;
    tick(10);
    check("reset idle", 4'b0011, {o_busy, o_drdy_status, o_scl_oe_n, o_sda_oe_n});
    setup_write(8'h12, 8'h5a);
    for (int s = 3; s >= 0; s--)
      setup_read(2'(s), 8'h20 + 8'(16 * s));
    refused();
    data_mode();
    latched_zero();
    disable_iface();
    report_and_stop();
  end
endmodule
`default_nettype wire
